// file: shared/axis_pkg.sv
/*
 Shared constants, modes and carriers for one motion axis:
 divider, pulse timing, drive states and config/status groups.
 Assumes a single core clock; nothing here holds logic.
*/
package axis_pkg;
   // Core clock and the divided internal tick
   localparam int CORE_CLK_HZ = 40_000_000;
   localparam int SCLK_DIV = 2;
   localparam int SCLK_HZ = CORE_CLK_HZ / SCLK_DIV;
   // Pulse period, in internal ticks
   localparam logic [15:0] MIN_PERIOD = 16'h0002;
   localparam logic [15:0] FRAC_RESET = 16'h0000;
   // Pulses issued during a decelerating stop
   localparam logic [7:0] DECEL_STOP_PULSES = 8'h08;
   // Values after reset, and the one-count step
   localparam logic signed [31:0] COUNT_RESET = 32'sh00000000;
   localparam logic signed [31:0] CMP_RESET = 32'sh00000000;
   localparam logic signed [31:0] COUNT_ONE = 32'sh00000001;

   typedef enum logic [1:0] {
      PH_CONST = 2'b00,
      PH_ACCEL = 2'b01,
      PH_DECEL = 2'b10
   } speed_phase_e;

   typedef enum logic [1:0] {
      DRV_IDLE = 2'b00,
      DRV_RUN = 2'b01,
      DRV_DECEL_STOP = 2'b10
   } drive_state_e;

   typedef enum logic {
      ENC_QUAD = 1'b0,
      ENC_UPDOWN = 1'b1
   } enc_mode_e;

   // Compare and ring configuration
   typedef struct packed {
      logic compare_source_select;
      logic soft_limit_upper_en;
      logic soft_limit_lower_en;
      logic wrap_enable;
   } compare_cfg_s;

   // Home clear configuration for the third stop input
   typedef struct packed {
      logic clear_enable;
      logic stop_input_two_enable;
      logic stop_input_two_level;
   } home_cfg_s;

   // Status flags
   typedef struct packed {
      logic upper_soft_limit_flag;
      logic lower_compare_flag;
      logic upper_compare_flag;
   } status_s;
endpackage

// file: hw/drive_pulse_gen.sv
/*
 Drive pulse period timer with fractional period mixing and
 phase-dependent duty. Assumes tick is a one-cycle enable at the
 internal rate and that run/abort come from the same clock.
*/
`timescale 1ns/1ps
module drive_pulse_gen (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Control
   input wire logic tick,
   input wire logic run,
   input wire logic abort,
   input wire logic [15:0] period_int,
   input wire logic [15:0] period_frac,
   input wire axis_pkg::speed_phase_e phase,
   // Pulse
   output logic pulse,
   output logic period_start
);
   logic [15:0] acc_q;
   logic [16:0] seg_q, high_len_q, low_len_q;
   logic pulse_q, busy_q, start_q;
   logic [16:0] sum, period, half, short_part, high_len, low_len;
   logic [15:0] base;
   logic begin_period;

   // Period of the next pulse: integer part plus fraction carry
   always_comb begin
      sum = {1'b0, acc_q} + {1'b0, period_frac};
      base = (period_int < axis_pkg::MIN_PERIOD) ? axis_pkg::MIN_PERIOD : period_int;
      period = {1'b0, base} + {16'h0000, sum[16]}; // [R5]
      half = period >> 1;
      short_part = half - (half >> 1);
      case (phase)
         axis_pkg::PH_ACCEL: low_len = short_part; // [R3]
         axis_pkg::PH_DECEL: low_len = period - short_part; // [R3]
         default: low_len = half; // [R2]
      endcase
      high_len = period - low_len;
   end

   // Periods chain on ticks, so error stays within one tick
   assign begin_period = run && !abort &&
      (!busy_q || (tick && !pulse_q && seg_q == 17'h00000)); // [R1]

   // Segment timer and level
   always_ff @(posedge core_clk) begin
      if (!rstn || abort) begin
         pulse_q <= 1'b0;
         busy_q <= 1'b0;
         seg_q <= 17'h00000;
      end else if (begin_period) begin
         pulse_q <= 1'b1;
         busy_q <= 1'b1;
         seg_q <= high_len - 17'h00001;
      end else if (tick && busy_q) begin
         if (seg_q != 17'h00000) begin
            seg_q <= seg_q - 17'h00001;
         end else if (pulse_q) begin
            pulse_q <= 1'b0;
            seg_q <= low_len_q - 17'h00001;
         end else begin
            busy_q <= 1'b0;
         end
      end
   end

   // Fraction accumulator and captured lengths
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         acc_q <= axis_pkg::FRAC_RESET;
         high_len_q <= 17'h00000;
         low_len_q <= 17'h00000;
         start_q <= 1'b0;
      end else begin
         start_q <= begin_period;
         if (begin_period) begin
            acc_q <= sum[15:0]; // [R5]
            high_len_q <= high_len;
            low_len_q <= low_len;
         end
      end
   end

   assign pulse = pulse_q;
   assign period_start = start_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   AST_DUTY_EQUAL: assert property ( // [R2]
      begin_period && phase == axis_pkg::PH_CONST && !period[0]
      |=> high_len_q == low_len_q)
      else $error("constant phase duty not half");
   AST_ACCEL_SKEW: assert property ( // [R3]
      begin_period && phase == axis_pkg::PH_ACCEL && period >= 17'h00004
      |=> low_len_q < high_len_q)
      else $error("accel low part not shorter");
   AST_FRAC_MIX: assert property ( // [R5]
      begin_period |=> (high_len_q + low_len_q) - {1'b0, $past(base)} <= 17'h00001)
      else $error("period outside integer neighbours");
endmodule

// file: hw/axis_position_compare_unit.sv
/*
 One axis: internal tick divider, drive pulse control, logical and
 real position counters, compare flags, soft limit, variable ring
 and home clear from the third stop input.
 Assumes host-side strobes are on core_clk; encoder and stop pins
 are asynchronous and are synchronised here.
*/
// Operation
// R1 - Pulse period within one internal tick
// R2 - Constant speed pulses have equal halves
// R3 - Accel shortens low part, decel lengthens
// R4 - Internal tick is input clock over two
// R5 - Fractional periods mix neighbouring integer lengths
// R6 - Logical counter follows output pulse direction
// R7 - Real counter from quadrature or up/down
// R8 - Signed 32-bit counters, host writable anytime
// R9 - Select bit picks compare source counter
// R10 - Upper flag when source above upper
// R11 - Lower flag when source below lower
// R12 - Soft limit exceeded: decel stop, set flag
// R13 - Soft limit flag clears below upper value
// R14 - Compare registers host writable anytime
// R15 - Default full 32-bit wraparound both ways
// R16 - Ring: logical to upper, real to lower
// R17 - Ring for both counters; disables soft limit
// R18 - Home active rise: stop, clear real counter
// R19 - Only third stop input clears counter
// R20 - Drive below initial speed: constant speed
// R21 - Home pulse held long enough by source
// R22 - Already active at configuration still clears
// R23 - Compare conditions evaluated every cycle
`timescale 1ns/1ps
module axis_position_compare_unit (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Drive commands
   input wire logic drive_start_pos,
   input wire logic drive_start_neg,
   input wire logic drive_stop,
   input wire logic [15:0] period_int,
   input wire logic [15:0] period_frac,
   input wire axis_pkg::speed_phase_e speed_phase,
   input wire logic [15:0] drive_speed,
   input wire logic [15:0] initial_speed,
   // Host writes
   input wire logic [31:0] host_wr_data,
   input wire logic logical_wr_en,
   input wire logic real_wr_en,
   input wire logic cmp_upper_wr_en,
   input wire logic cmp_lower_wr_en,
   // Configuration
   input wire axis_pkg::compare_cfg_s compare_cfg,
   input wire axis_pkg::home_cfg_s home_cfg,
   input wire axis_pkg::enc_mode_e enc_mode,
   // Field pins
   input wire logic enc_a,
   input wire logic enc_b,
   input wire logic home_stop_input_two,
   // Outputs
   output logic drive_pulse_pos,
   output logic drive_pulse_neg,
   output logic driving,
   output logic signed [31:0] logical_count,
   output logic signed [31:0] real_count,
   output axis_pkg::status_s status
);
   axis_pkg::drive_state_e state_q;
   axis_pkg::speed_phase_e gen_phase;
   axis_pkg::status_s status_q;
   logic sclk_en_q;
   logic dir_q;
   logic [7:0] stop_cnt_q;
   logic pulse_pos_q, pulse_neg_q;
   logic signed [31:0] logical_q, real_q;
   logic signed [31:0] cmp_upper_q, cmp_lower_q;
   logic signed [31:0] sel_val;
   logic [2:0] meta_q, sync_q, prev_q;
   logic home_armed_q;
   logic driving_q;
   logic gen_pulse, gen_start;
   logic enc_up, enc_dn;
   logic home_active, home_cond, home_clear;
   logic soft_active, soft_trip, upper_gt, lower_lt;
   logic gen_run, gen_abort, start_req;

   // Step a counter one place, on a full or variable ring
   function automatic logic signed [31:0] ring_step(
      input logic signed [31:0] v,
      input logic up,
      input logic ring,
      input logic signed [31:0] top);
      logic signed [31:0] r;
      r = up ? v + axis_pkg::COUNT_ONE : v - axis_pkg::COUNT_ONE; // [R15]
      if (ring && up && v == top) begin
         r = axis_pkg::COUNT_RESET; // [R16]
      end else if (ring && !up && v == axis_pkg::COUNT_RESET) begin
         r = top; // [R16]
      end
      return r;
   endfunction

   // Internal tick: one core cycle in two
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         sclk_en_q <= 1'b0;
      end else begin
         sclk_en_q <= !sclk_en_q; // [R4]
      end
   end

   // Two-flop synchronisers; prev_q is only for edge decode
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         meta_q <= 3'h0;
         sync_q <= 3'h0;
         prev_q <= 3'h0;
      end else begin
         meta_q <= {home_stop_input_two, enc_b, enc_a};
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Encoder decode; A leading B counts up
   always_comb begin
      enc_up = 1'b0;
      enc_dn = 1'b0;
      case (enc_mode)
         axis_pkg::ENC_UPDOWN: begin
            enc_up = sync_q[0] && !prev_q[0] && !(sync_q[1] && !prev_q[1]); // [R7]
            enc_dn = sync_q[1] && !prev_q[1] && !(sync_q[0] && !prev_q[0]); // [R7]
         end
         default: begin
            if ((sync_q[0] ^ prev_q[0]) ^ (sync_q[1] ^ prev_q[1])) begin
               enc_up = sync_q[0] ^ prev_q[1]; // [R7]
               enc_dn = !(sync_q[0] ^ prev_q[1]); // [R7]
            end
         end
      endcase
   end

   // Home clear fires on the rise of the armed condition, so an input
   // already active when configured also clears; no filter here, the
   // source must hold the level past the synchroniser delay
   assign home_active = sync_q[2] == home_cfg.stop_input_two_level; // [R21]
   assign home_cond = home_cfg.clear_enable && home_cfg.stop_input_two_enable
      && home_active;
   assign home_clear = home_cond && !home_armed_q; // [R18] [R22]

   // Remember the armed condition for edge detection
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         home_armed_q <= 1'b0;
      end else begin
         home_armed_q <= home_cond;
      end
   end

   // Compare source and conditions, every cycle
   assign sel_val = compare_cfg.compare_source_select ? real_q : logical_q; // [R9]
   assign upper_gt = sel_val > cmp_upper_q; // [R23]
   assign lower_lt = sel_val < cmp_lower_q; // [R23]
   // Ring and soft limit share the compare registers
   assign soft_active = compare_cfg.soft_limit_upper_en &&
      compare_cfg.soft_limit_lower_en && !compare_cfg.wrap_enable; // [R17]
   assign soft_trip = soft_active && upper_gt && state_q == axis_pkg::DRV_RUN;

   // Status flags; a set wins over the automatic clear
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         status_q <= '0;
      end else begin
         status_q.upper_compare_flag <= upper_gt; // [R10]
         status_q.lower_compare_flag <= lower_lt; // [R11]
         if (soft_active && upper_gt && driving) begin
            status_q.upper_soft_limit_flag <= 1'b1; // [R12]
         end else if (!upper_gt && sel_val != cmp_upper_q) begin
            status_q.upper_soft_limit_flag <= 1'b0; // [R13]
         end
      end
   end

   // Compare registers, writable at any time
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         cmp_upper_q <= axis_pkg::CMP_RESET;
         cmp_lower_q <= axis_pkg::CMP_RESET;
      end else begin
         if (cmp_upper_wr_en) begin
            cmp_upper_q <= host_wr_data; // [R14]
         end
         if (cmp_lower_wr_en) begin
            cmp_lower_q <= host_wr_data; // [R14]
         end
      end
   end

   // Logical counter follows each issued pulse; host write wins
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         logical_q <= axis_pkg::COUNT_RESET;
      end else if (logical_wr_en) begin
         logical_q <= host_wr_data; // [R8]
      end else if (gen_start) begin
         logical_q <= ring_step(logical_q, dir_q, compare_cfg.wrap_enable,
            cmp_upper_q); // [R6] [R16]
      end
   end

   // Real counter; only the third stop input may clear it
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         real_q <= axis_pkg::COUNT_RESET;
      end else if (home_clear) begin
         real_q <= axis_pkg::COUNT_RESET; // [R18] [R19]
      end else if (real_wr_en) begin
         real_q <= host_wr_data; // [R8]
      end else if (enc_up || enc_dn) begin
         real_q <= ring_step(real_q, enc_up, compare_cfg.wrap_enable,
            cmp_lower_q); // [R7] [R16]
      end
   end

   // Drive sequencing; home clear and stop end the drive at once
   assign start_req = drive_start_pos || drive_start_neg;
   assign gen_abort = home_clear || drive_stop; // [R18]
   assign gen_run = state_q != axis_pkg::DRV_IDLE;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state_q <= axis_pkg::DRV_IDLE;
         driving_q <= 1'b0;
         dir_q <= 1'b1;
         stop_cnt_q <= 8'h00;
      end else begin
         case (state_q)
            axis_pkg::DRV_IDLE: begin
               if (start_req && !gen_abort) begin
                  state_q <= axis_pkg::DRV_RUN;
                  driving_q <= 1'b1;
                  dir_q <= drive_start_pos;
               end
            end
            axis_pkg::DRV_RUN: begin
               if (gen_abort) begin
                  state_q <= axis_pkg::DRV_IDLE; // [R18]
                  driving_q <= 1'b0;
               end else if (soft_trip) begin
                  state_q <= axis_pkg::DRV_DECEL_STOP; // [R12]
                  stop_cnt_q <= axis_pkg::DECEL_STOP_PULSES;
               end
            end
            axis_pkg::DRV_DECEL_STOP: begin
               if (gen_abort) begin
                  state_q <= axis_pkg::DRV_IDLE;
                  driving_q <= 1'b0;
               end else if (gen_start) begin
                  stop_cnt_q <= stop_cnt_q - 8'h01;
                  if (stop_cnt_q <= 8'h01) begin
                     state_q <= axis_pkg::DRV_IDLE;
                     driving_q <= 1'b0;
                  end
               end
            end
            default: begin
               state_q <= axis_pkg::DRV_IDLE;
               driving_q <= 1'b0;
            end
         endcase
      end
   end

   // Below the initial speed there is no ramp at all
   always_comb begin
      if (drive_speed < initial_speed) begin
         gen_phase = axis_pkg::PH_CONST; // [R20]
      end else if (state_q == axis_pkg::DRV_DECEL_STOP) begin
         gen_phase = axis_pkg::PH_DECEL; // [R12]
      end else begin
         gen_phase = speed_phase;
      end
   end

   // Pulse timer, advanced by the internal tick
   drive_pulse_gen u_pulse (
      .core_clk(core_clk),
      .rstn(rstn),
      .tick(sclk_en_q),
      .run(gen_run),
      .abort(gen_abort),
      .period_int(period_int),
      .period_frac(period_frac),
      .phase(gen_phase),
      .pulse(gen_pulse),
      .period_start(gen_start)
   );

   // Steer the pulse to its direction pin; costs one cycle of latency
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pulse_pos_q <= 1'b0;
         pulse_neg_q <= 1'b0;
      end else begin
         pulse_pos_q <= gen_pulse && dir_q && !gen_abort;
         pulse_neg_q <= gen_pulse && !dir_q && !gen_abort;
      end
   end

   assign drive_pulse_pos = pulse_pos_q;
   assign drive_pulse_neg = pulse_neg_q;
   assign driving = driving_q; // Mirrors state, kept as its own flop
   assign logical_count = logical_q;
   assign real_count = real_q;
   assign status = status_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   AST_SCLK_DIV: assert property ( // [R4]
      sclk_en_q |=> !sclk_en_q ##1 sclk_en_q)
      else $error("internal tick not one in two");
   AST_LOGIC_STEP: assert property ( // [R6]
      gen_start && dir_q && !logical_wr_en && !compare_cfg.wrap_enable
      |=> logical_q == $past(logical_q) + axis_pkg::COUNT_ONE)
      else $error("logical counter missed up step");
   AST_UPPER_FLAG: assert property ( // [R10]
      ##1 status_q.upper_compare_flag == $past((compare_cfg.compare_source_select
      ? real_q : logical_q) > cmp_upper_q))
      else $error("upper compare flag wrong");
   AST_LOWER_FLAG: assert property ( // [R11]
      ##1 status_q.lower_compare_flag == $past((compare_cfg.compare_source_select
      ? real_q : logical_q) < cmp_lower_q))
      else $error("lower compare flag wrong");
   AST_RING_UP: assert property ( // [R16]
      gen_start && dir_q && compare_cfg.wrap_enable && !logical_wr_en
      && logical_q == cmp_upper_q |=> logical_q == axis_pkg::COUNT_RESET)
      else $error("logical ring did not return to zero");
   AST_HOME_CLEAR: assert property ( // [R18]
      home_clear |=> real_q == axis_pkg::COUNT_RESET && !driving
      ##1 !drive_pulse_pos && !drive_pulse_neg)
      else $error("home clear did not clear and stop");
   AST_SLIMIT_STOP: assert property ( // [R12]
      soft_trip && !gen_abort |=> state_q == axis_pkg::DRV_DECEL_STOP
      && status_q.upper_soft_limit_flag)
      else $error("soft limit did not start decel stop");
   AST_SLIMIT_CLEAR: assert property ( // [R13]
      sel_val < cmp_upper_q |=> !status_q.upper_soft_limit_flag)
      else $error("soft limit flag did not clear");
   AST_NO_SLIMIT_RING: assert property ( // [R17]
      compare_cfg.wrap_enable && state_q == axis_pkg::DRV_RUN
      |=> state_q != axis_pkg::DRV_DECEL_STOP)
      else $error("soft limit active with ring");
   AST_CONST_BELOW_INIT: assert property ( // [R20]
      drive_speed < initial_speed |-> gen_phase == axis_pkg::PH_CONST)
      else $error("ramp below initial speed");

   COV_DRIVE: cover property (driving && gen_start ##[1:200] !driving);
   COV_HOME: cover property (driving && home_clear);
   COV_RING: cover property (compare_cfg.wrap_enable && gen_start
      && logical_q == cmp_upper_q);
   COV_SLIMIT: cover property (soft_trip);
endmodule

// file: verif/sensor_model.sv
/*
 Field-side model: encoder in quadrature or up/down form and the
 third stop input. Assumes the bench calls its tasks at falling edges.
*/
`timescale 1ns/1ps
module sensor_model (
   // Clock and mode
   input wire logic core_clk,
   input wire axis_pkg::enc_mode_e enc_mode,
   // Field pins
   output logic enc_a,
   output logic enc_b,
   output logic home_pin
);
   logic [1:0] ph;
   // Idle pins at time zero
   initial begin
      ph = 2'b00;
      enc_a = 1'b0;
      enc_b = 1'b0;
      home_pin = 1'b0;
   end
   // Each level stays 4 cycles so the 2-flop synchroniser cannot miss it
   task automatic hold();
      repeat (4) @(negedge core_clk);
   endtask
   // One count step; A leads B when counting up
   task automatic step(input logic up);
      if (enc_mode == axis_pkg::ENC_QUAD) begin
         ph = up ? ph + 2'b01 : ph - 2'b01;
         enc_a = ph[1] ^ ph[0];
         enc_b = ph[1];
         hold();
      end else begin
         if (up) enc_a = 1'b1;
         else enc_b = 1'b1;
         hold();
         enc_a = 1'b0;
         enc_b = 1'b0;
         hold();
      end
   endtask
   // Home level held well past four input clocks
   task automatic set_home(input logic v);
      home_pin = v;
      repeat (8) @(negedge core_clk);
   endtask
endmodule

// file: verif/testbench.sv
/*
 Self-checking bench for one axis: pulse timing, counters, compare,
 soft limit, ring and home clear. Assumes the sensor model on the
 field pins and a 40 MHz core clock.
*/
`timescale 1ns/1ps
module testbench;
   // Bench signals
   logic core_clk, rstn, start_p, start_n, stop, dneg;
   logic [15:0] p_int, p_frac, dspd, ispd;
   logic [31:0] wdata;
   logic [3:0] wen;
   axis_pkg::speed_phase_e phase;
   axis_pkg::compare_cfg_s ccfg;
   axis_pkg::home_cfg_s hcfg;
   axis_pkg::enc_mode_e emode;
   logic enc_a, enc_b, home_pin, pp, pn, driving;
   logic signed [31:0] lcnt, rcnt;
   axis_pkg::status_s status;
   int bad_count, compares, cycles, hi, lo, h2, l2, x;
   axis_pkg::speed_phase_e ph_t[4] = '{axis_pkg::PH_CONST, axis_pkg::PH_ACCEL,
      axis_pkg::PH_DECEL, axis_pkg::PH_ACCEL};
   int pt[4] = '{4, 8, 8, 4};
   int eh[4] = '{4, 12, 4, 4};
   int el[4] = '{4, 4, 12, 4};
   wire sel = dneg ? pn : pp;

   axis_position_compare_unit DUT (
      .core_clk(core_clk), .rstn(rstn),
      .drive_start_pos(start_p), .drive_start_neg(start_n), .drive_stop(stop),
      .period_int(p_int), .period_frac(p_frac), .speed_phase(phase),
      .drive_speed(dspd), .initial_speed(ispd), .host_wr_data(wdata),
      .logical_wr_en(wen[0]), .real_wr_en(wen[1]),
      .cmp_upper_wr_en(wen[2]), .cmp_lower_wr_en(wen[3]),
      .compare_cfg(ccfg), .home_cfg(hcfg), .enc_mode(emode),
      .enc_a(enc_a), .enc_b(enc_b), .home_stop_input_two(home_pin),
      .drive_pulse_pos(pp), .drive_pulse_neg(pn), .driving(driving),
      .logical_count(lcnt), .real_count(rcnt), .status(status)
   );
   sensor_model sensors (
      .core_clk(core_clk), .enc_mode(emode),
      .enc_a(enc_a), .enc_b(enc_b), .home_pin(home_pin)
   );

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // Hang guard, far above the expected run length
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("Error t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic complete_run();
      $display("Mismatches %0d in %0d compares", bad_count, compares);
      if (bad_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Wait for the selected pulse to reach a level, counting cycles
   task automatic lvl(input logic v, output int n);
      n = 0;
      while (sel !== v && n < 400) begin
         @(negedge core_clk);
         n++;
      end
   endtask
   task automatic meas(output int h, output int l);
      lvl(1'b1, x);
      lvl(1'b0, h);
      lvl(1'b1, l);
   endtask
   task automatic halt();
      stop = 1'b1;
      @(negedge core_clk);
      stop = 1'b0;
      repeat (3) @(negedge core_clk);
   endtask
   // Start a drive, let n pulses out, stop unless kept running
   task automatic go(input logic neg, input int n, input logic keep);
      dneg = neg;
      start_p = !neg;
      start_n = neg;
      @(negedge core_clk);
      start_p = 1'b0;
      start_n = 1'b0;
      repeat (n) begin
         lvl(1'b1, x);
         lvl(1'b0, x);
      end
      if (!keep) halt();
   endtask
   // Host write: strobe one-hot {lower, upper, real, logical}
   task automatic wr(input logic [3:0] w, input logic [31:0] d);
      wen = w;
      wdata = d;
      @(negedge core_clk);
      wen = 4'h0;
      repeat (2) @(negedge core_clk);
   endtask

   // Main sequence
   initial begin
      {start_p, start_n, stop, dneg, rstn} = 5'h00;
      {p_int, p_frac, dspd, ispd} = {16'h0004, 16'h0000, 16'h0002, 16'h0001};
      {wdata, wen} = 36'h000000000;
      phase = axis_pkg::PH_CONST;
      ccfg = '0;
      hcfg = '0;
      emode = axis_pkg::ENC_UPDOWN;
      repeat (2) @(negedge core_clk);
      rstn = 1'b1;
      chk(lcnt, 32'h00000000);
      chk(32'(status), 32'h00000000);
      // Duty and period per phase, last entry below initial speed;
      // the first period is skipped, its start is not tick aligned
      for (int i = 0; i < 4; i++) begin
         phase = ph_t[i];
         p_int = 16'(pt[i]);
         dspd = (i == 3) ? 16'h0001 : 16'h0002;
         ispd = (i == 3) ? 16'h0002 : 16'h0001;
         go(1'b0, 1, 1'b1);
         meas(hi, lo);
         halt();
         chk(hi, eh[i]);
         chk(lo, el[i]);
      end
      // Half-tick fraction: two periods sum to nine ticks
      {phase, p_int, p_frac, dspd} = {axis_pkg::PH_CONST, 16'h0004, 16'h8000, 16'h0002};
      go(1'b0, 1, 1'b1);
      meas(hi, lo);
      meas(h2, l2);
      halt();
      p_frac = 16'h0000;
      chk(hi + lo + h2 + l2, 18);
      // Full-width wrap in both directions
      wr(4'h1, 32'hFFFFFFFF);
      go(1'b0, 1, 1'b0);
      chk(lcnt, 32'h00000000);
      go(1'b1, 2, 1'b0);
      chk(lcnt, 32'hFFFFFFFE);
      go(1'b0, 3, 1'b0);
      chk(lcnt, 32'h00000001);
      // Compare flags against either source
      wr(4'h4, 32'h0000000A);
      wr(4'h8, 32'hFFFFFFFB);
      wr(4'h1, 32'h0000000B);
      chk(32'(status), 32'h00000001);
      wr(4'h1, 32'h80000000);
      chk(lcnt, 32'h80000000);
      chk(32'(status), 32'h00000002);
      ccfg.compare_source_select = 1'b1;
      wr(4'h2, 32'h00000014);
      chk(32'(status), 32'h00000001);
      wr(4'h2, 32'h00000000);
      chk(32'(status), 32'h00000000);
      // Soft limit on the logical counter
      ccfg = '{1'b0, 1'b1, 1'b1, 1'b0};
      wr(4'h4, 32'h00000002);
      wr(4'h1, 32'h00000000);
      go(1'b0, 0, 1'b1);
      for (int k = 0; k < 400 && status.upper_soft_limit_flag !== 1'b1; k++)
         @(negedge core_clk);
      chk(32'(status.upper_soft_limit_flag), 32'h1);
      for (int k = 0; k < 400 && driving !== 1'b0; k++) @(negedge core_clk);
      chk(32'(driving), 32'h0);
      wr(4'h1, 32'h00000000);
      chk(32'(status.upper_soft_limit_flag), 32'h0);
      // Ring on: limit inert, logical wraps at upper, real at lower
      ccfg.wrap_enable = 1'b1;
      go(1'b0, 5, 1'b0);
      chk(lcnt, 32'h00000002);
      chk(32'(status.upper_soft_limit_flag), 32'h0);
      go(1'b1, 3, 1'b0);
      chk(lcnt, 32'h00000002);
      wr(4'h8, 32'h00000001);
      wr(4'h2, 32'h00000001);
      sensors.step(1'b1);
      chk(rcnt, 32'h00000000);
      sensors.step(1'b0);
      chk(rcnt, 32'h00000001);
      // Plain encoder counting, both input forms
      ccfg = '0;
      wr(4'h2, 32'h00000000);
      sensors.step(1'b1);
      sensors.step(1'b1);
      emode = axis_pkg::ENC_QUAD;
      repeat (3) sensors.step(1'b1);
      chk(rcnt, 32'h00000005);
      repeat (6) sensors.step(1'b0);
      repeat (4) @(negedge core_clk);
      chk(rcnt, 32'hFFFFFFFF);
      // Home clear during a drive, then with the pin already active
      hcfg = '{1'b1, 1'b1, 1'b1};
      wr(4'h2, 32'h00000064);
      go(1'b0, 2, 1'b1);
      sensors.set_home(1'b1);
      chk(rcnt, 32'h00000000);
      chk(32'(driving), 32'h0);
      sensors.set_home(1'b0);
      hcfg = '0;
      wr(4'h2, 32'h00000032);
      sensors.set_home(1'b1);
      hcfg = '{1'b1, 1'b1, 1'b1};
      repeat (6) @(negedge core_clk);
      chk(rcnt, 32'h00000000);
      // Low active level: a high pin is idle, its fall clears
      wr(4'h2, 32'h00000032);
      hcfg = '{1'b1, 1'b1, 1'b0};
      chk(rcnt, 32'h00000032);
      sensors.set_home(1'b0);
      chk(rcnt, 32'h00000000);
      complete_run();
   end
endmodule
